// file: include/station_pkg.sv
// shared constants, types and register map for the station status word writer
package station_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int WORD_W = 16;
    localparam int MEM_ADDR_W = 12;
    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_TARGET = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_ERRORS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_NOTIFY = 8'h0c;
    // status word field positions
    localparam int BIT_BOARD_ERR = 15;
    localparam int BIT_HOST_ERR = 14;
    localparam int STATION_LSB = 0;
    localparam int STATION_W = 4;
    localparam logic [STATION_W-1:0] STATION_NONE = 4'h0;
    // target register fields
    localparam int TGT_VALID_BIT = 31;
    localparam int TGT_BIT_FLAG = 30;
    localparam int TGT_AREA_LSB = 16;
    localparam int TGT_AREA_W = 2;
    localparam int TGT_ADDR_LSB = 0;
    // errors register fields
    localparam int ERR_BOARD_BIT = 0;
    localparam int ERR_HOST_BIT = 1;
    // notify register fields
    localparam int NTF_PROTO_BIT = 0;
    localparam int NTF_HOSTREQ_BIT = 1;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
    localparam logic [MEM_ADDR_W-1:0] MEM_ADDR_ZERO = 12'h000;
    // memory areas
    typedef enum logic [1:0] {
        AREA_SYSTEM = 2'b00,
        AREA_USER_WORD = 2'b01,
        AREA_USER_RETAINED = 2'b10,
        AREA_NONE = 2'b11
    } mem_area_t;
    // register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    // memory word write toward the terminal internal memory
    typedef struct packed {
        logic valid;
        mem_area_t area;
        logic [MEM_ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } mem_wr_t;
endpackage

// file: core/station_line_sync.sv
// three-stage synchroniser with agreement filter for the station id lines
`timescale 1ns/1ps
module station_line_sync #(
    parameter int WIDTH = 4
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] stable_out
);
    logic [WIDTH-1:0] s1_r, s2_r, s3_r, out_r;
    logic [WIDTH-1:0] out_nxt;

    // per line: accept a new level only once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_line
            always_comb begin
                out_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : out_r[g];
            end
        end
    endgenerate

    // first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            out_r <= '0;
        end else begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= out_nxt;
        end
    end

    assign stable_out = out_r;
endmodule // station_line_sync

// file: core/station_status_writer.sv
// station detection status word builder, register slave and memory word writer
`timescale 1ns/1ps
// Function
// - station lines 1 to 4 land in status bits 0 to 3 in order
// - station value zero means no box, 1 to 15 is binary station number
// - a line reads 1 when its level is on, 0 when off
// - bit 15 set on board fault blocking function key status, clear otherwise
// - bit 14 set on host communications error, clear when normal
// - status word goes to exactly one word in one user memory area
// - target must be a word address in user memory, never system area
// - after reset no target is assigned and nothing is written
// - in command-response mode key and stop notifications go to terminal memory only
module station_status_writer
    import station_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input station_pkg::reg_req_t reg_req,
    output logic [station_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [3:0] station_id_line,
    input wire logic board_fault,
    input wire logic host_comm_error,
    output station_pkg::mem_wr_t mem_wr,
    output logic notify_to_host
);
    import station_pkg::*;

    logic [STATION_W-1:0] station_sync;
    logic [WORD_W-1:0] word_now;
    logic [WORD_W-1:0] word_last_r, word_last_nxt;
    logic tgt_valid_r, tgt_valid_nxt;
    logic tgt_dirty_r, tgt_dirty_nxt;
    logic notify_r, notify_nxt;
    mem_area_t tgt_area_r, tgt_area_nxt;
    logic [MEM_ADDR_W-1:0] tgt_addr_r, tgt_addr_nxt;
    logic sw_board_r, sw_board_nxt;
    logic sw_host_r, sw_host_nxt;
    logic proto_cr_r, proto_cr_nxt;
    logic host_req_r, host_req_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    mem_wr_t wr_r, wr_nxt;
    logic need_write;
    mem_area_t req_area;
    logic req_ok;

    // pin lines from the box are asynchronous
    station_line_sync #(
        .WIDTH(STATION_W)
    ) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .async_in(station_id_line),
        .stable_out(station_sync)
    );

    // status word assembly; a line at on level is 1, all zero means no box
    always_comb begin
        word_now = WORD_ZERO; // reserved bits stay zero
        word_now[STATION_LSB +: STATION_W] = station_sync;
        word_now[BIT_BOARD_ERR] = board_fault | sw_board_r;
        word_now[BIT_HOST_ERR] = host_comm_error | sw_host_r;
    end

    // a target request is taken only as a word address in a user area
    assign req_area = mem_area_t'(reg_req.wdata[TGT_AREA_LSB +: TGT_AREA_W]);
    assign req_ok = !reg_req.wdata[TGT_BIT_FLAG] &&
                    (req_area == AREA_USER_WORD || req_area == AREA_USER_RETAINED);

    // register writes and read data
    always_comb begin
        tgt_valid_nxt = tgt_valid_r;
        tgt_area_nxt = tgt_area_r;
        tgt_addr_nxt = tgt_addr_r;
        sw_board_nxt = sw_board_r;
        sw_host_nxt = sw_host_r;
        proto_cr_nxt = proto_cr_r;
        host_req_nxt = host_req_r;
        rdata_nxt = RD_ZERO;
        if (reg_req.wr) begin
            if (reg_req.addr == OFS_TARGET) begin
                // rejected target leaves the old one intact; clearing the valid bit unassigns
                if (!reg_req.wdata[TGT_VALID_BIT]) begin
                    tgt_valid_nxt = 1'b0;
                end else if (req_ok) begin
                    tgt_valid_nxt = 1'b1;
                    tgt_area_nxt = req_area;
                    tgt_addr_nxt = reg_req.wdata[TGT_ADDR_LSB +: MEM_ADDR_W];
                end
            end else if (reg_req.addr == OFS_ERRORS) begin
                sw_board_nxt = reg_req.wdata[ERR_BOARD_BIT];
                sw_host_nxt = reg_req.wdata[ERR_HOST_BIT];
            end else if (reg_req.addr == OFS_NOTIFY) begin
                proto_cr_nxt = reg_req.wdata[NTF_PROTO_BIT];
                host_req_nxt = reg_req.wdata[NTF_HOSTREQ_BIT];
            end
        end
        if (reg_req.rd) begin
            if (reg_req.addr == OFS_STATUS) begin
                // live word, so software sees the lines even with no target assigned
                rdata_nxt = {{(DATA_W-WORD_W){1'b0}}, word_now};
            end else if (reg_req.addr == OFS_TARGET) begin
                rdata_nxt[TGT_VALID_BIT] = tgt_valid_r;
                rdata_nxt[TGT_AREA_LSB +: TGT_AREA_W] = tgt_area_r;
                rdata_nxt[TGT_ADDR_LSB +: MEM_ADDR_W] = tgt_addr_r;
            end else if (reg_req.addr == OFS_ERRORS) begin
                rdata_nxt[ERR_BOARD_BIT] = sw_board_r;
                rdata_nxt[ERR_HOST_BIT] = sw_host_r;
            end else if (reg_req.addr == OFS_NOTIFY) begin
                rdata_nxt[NTF_PROTO_BIT] = proto_cr_r;
                rdata_nxt[NTF_HOSTREQ_BIT] = host_req_r;
            end
        end
    end

    // rewrite on change of the word, or once when a target becomes newly assigned
    assign need_write = tgt_valid_r && ((word_now != word_last_r) || tgt_dirty_r);

    // dirty flag: a taken target sets it, the memory write clears it;
    // a new target in the same cycle as a write wins, so the new word is still refreshed
    always_comb begin
        tgt_dirty_nxt = tgt_dirty_r;
        if (need_write) begin
            tgt_dirty_nxt = 1'b0;
        end
        if (reg_req.wr && reg_req.addr == OFS_TARGET) begin
            if (!reg_req.wdata[TGT_VALID_BIT]) begin
                tgt_dirty_nxt = 1'b0;
            end else if (req_ok) begin
                tgt_dirty_nxt = 1'b1;
            end
        end
    end

    // memory word write, a one-cycle pulse per refresh toward exactly one word
    always_comb begin
        word_last_nxt = word_last_r;
        wr_nxt = wr_r;
        wr_nxt.valid = 1'b0;
        if (need_write) begin
            wr_nxt.valid = 1'b1;
            wr_nxt.area = tgt_area_r;
            wr_nxt.addr = tgt_addr_r;
            wr_nxt.data = word_now;
            word_last_nxt = word_now;
        end
    end

    // command-response mode keeps stop and key notifications inside terminal memory
    assign notify_nxt = host_req_r && !proto_cr_r;

    // state registers only; nothing is targeted after reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tgt_valid_r <= 1'b0;
            tgt_area_r <= AREA_NONE;
            tgt_addr_r <= MEM_ADDR_ZERO;
            tgt_dirty_r <= 1'b0;
            sw_board_r <= 1'b0;
            sw_host_r <= 1'b0;
            proto_cr_r <= 1'b0;
            host_req_r <= 1'b0;
            rdata_r <= RD_ZERO;
            word_last_r <= WORD_ZERO;
            wr_r <= '0;
            notify_r <= 1'b0;
        end else begin
            tgt_valid_r <= tgt_valid_nxt;
            tgt_area_r <= tgt_area_nxt;
            tgt_addr_r <= tgt_addr_nxt;
            tgt_dirty_r <= tgt_dirty_nxt;
            sw_board_r <= sw_board_nxt;
            sw_host_r <= sw_host_nxt;
            proto_cr_r <= proto_cr_nxt;
            host_req_r <= host_req_nxt;
            rdata_r <= rdata_nxt;
            word_last_r <= word_last_nxt;
            wr_r <= wr_nxt;
            notify_r <= notify_nxt;
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata = rdata_r;
    assign mem_wr = wr_r;
    assign notify_to_host = notify_r;

    // a target accepted on the bus, then the forced refresh of that word
    sequence target_taken;
        reg_req.wr && reg_req.addr == OFS_TARGET && reg_req.wdata[TGT_VALID_BIT] && req_ok;
    endsequence

    sequence dirty_then_write;
        tgt_dirty_r ##1 mem_wr.valid;
    endsequence

    // a new target is always written once, even if the word did not change
    first_write_a: assert property (
        @(posedge core_clk) disable iff (reset)
        target_taken |=> dirty_then_write)
        else $error("new target was not written");

    // writes only ever land in a user area
    write_area_a: assert property (
        @(posedge core_clk) disable iff (reset)
        mem_wr.valid |-> (mem_wr.area == AREA_USER_WORD || mem_wr.area == AREA_USER_RETAINED))
        else $error("memory write outside user areas");

    // no target, no write
    no_target_a: assert property (
        @(posedge core_clk) disable iff (reset)
        !tgt_valid_r |=> !mem_wr.valid)
        else $error("memory write without a target");

    // reserved field always written as zero
    reserved_zero_a: assert property (
        @(posedge core_clk) disable iff (reset)
        mem_wr.valid |-> (mem_wr.data[BIT_HOST_ERR-1:STATION_W] == 10'h000))
        else $error("reserved bits not zero");

    // station lines land in the low nibble in order
    station_copy_a: assert property (
        @(posedge core_clk) disable iff (reset)
        need_write |=> (mem_wr.data[STATION_LSB +: STATION_W] == $past(station_sync)))
        else $error("station number not copied");

    // board fault shows in the top bit
    board_flag_a: assert property (
        @(posedge core_clk) disable iff (reset)
        need_write && board_fault |=> mem_wr.data[BIT_BOARD_ERR])
        else $error("board error bit missing");

    // host communications error shows in bit fourteen
    host_flag_a: assert property (
        @(posedge core_clk) disable iff (reset)
        need_write && host_comm_error |=> mem_wr.data[BIT_HOST_ERR])
        else $error("host error bit missing");

    // command-response mode never notifies the host
    notify_block_a: assert property (
        @(posedge core_clk) disable iff (reset)
        proto_cr_r |=> !notify_to_host)
        else $error("host notified in command-response mode");
endmodule // station_status_writer

// file: testbench/station_box.sv
// junction box model that drives the four station id lines
`timescale 1ns/1ps
module station_box (
    input wire logic [3:0] station_no,
    input wire logic attached,
    output logic [3:0] station_id_line
);
    // one terminal per host port, so a single box drives these lines
    // rotary switch wired to plain binary; a detached box leaves every line off
    assign station_id_line = attached ? station_no : 4'h0;
endmodule // station_box

// file: testbench/tb_top.sv
// self-checking bench for the station status word writer
`timescale 1ns/1ps
module tb_top;
    import station_pkg::*;
    logic core_clk, reset, board_fault, host_comm_error, attached, notify_to_host;
    logic [3:0] station_no, station_id_line;
    reg_req_t reg_req;
    logic [DATA_W-1:0] reg_rdata;
    mem_wr_t mem_wr, last_wr;
    int err_count = 0, compares = 0, cycles = 0, wr_seen = 0;
    logic [31:0] rng = 32'h0000_3a06;
    station_box box_u (.station_no(station_no), .attached(attached), .station_id_line(station_id_line));
    station_status_writer dut_u (.core_clk(core_clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .station_id_line(station_id_line), .board_fault(board_fault), .host_comm_error(host_comm_error),
        .mem_wr(mem_wr), .notify_to_host(notify_to_host));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // keep the last memory write; a hang is cut short by the cycle ceiling
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (mem_wr.valid === 1'b1) begin
            last_wr <= mem_wr;
            wr_seen <= wr_seen + 1;
        end
        if (cycles == 6000) begin
            err_count = err_count + 1;
            end_sim;
        end
    end
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [15:0] exp_word(logic [3:0] s, logic b, logic h);
        return {b, h, 10'h000, s};
    endfunction
    task automatic check(string name, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        reg_req.wr <= 1'b0;
    endtask
    // set the box and errors, let the lines settle, then read back and look at memory
    task automatic apply(logic [3:0] s, logic b, logic h, logic tgt);
        logic [15:0] e;
        @(posedge core_clk);
        e = exp_word(attached ? s : 4'h0, b, h);
        station_no <= s;
        board_fault <= b;
        host_comm_error <= h;
        repeat (20) @(posedge core_clk);
        reg_req <= '{addr: OFS_STATUS, wdata: RD_ZERO, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        reg_req.rd <= 1'b0;
        #1 check("status", e, reg_rdata[15:0]);
        if (tgt) begin
            check("mem data", e, last_wr.data);
            check("mem place", {2'b00, AREA_USER_RETAINED, 12'h123}, {2'b00, last_wr.area, last_wr.addr});
        end
    endtask
    initial begin
        reset = 1'b1;
        reg_req = '0;
        station_no = 4'h0;
        attached = 1'b1;
        board_fault = 1'b0;
        host_comm_error = 1'b0;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        // system area and bit targets must be refused, so nothing is written yet
        wr(OFS_TARGET, 32'h8000_0010);
        wr(OFS_TARGET, 32'hc001_0010);
        apply(4'h5, 1'b1, 1'b0, 1'b0);
        check("writes", 16'h0000, wr_seen[15:0]);
        wr(OFS_TARGET, 32'h8002_0123);
        for (int i = 0; i < 12; i++) begin
            apply(i[1:0] == 2'b00 ? 4'h0 : (i[0] ? 4'h1 : 4'hf), i[2], i[3], 1'b1);
        end
        // detaching the box reads as not connected
        attached <= 1'b0;
        apply(4'ha, 1'b0, 1'b1, 1'b1);
        attached <= 1'b1;
        // host notification allowed in multi-drop mode, blocked in command-response mode
        wr(OFS_NOTIFY, 32'h0000_0002);
        repeat (2) @(posedge core_clk);
        #1 check("notify", 16'h0001, {15'h0000, notify_to_host});
        wr(OFS_NOTIFY, 32'h0000_0003);
        repeat (2) @(posedge core_clk);
        #1 check("notify", 16'h0000, {15'h0000, notify_to_host});
        for (int i = 0; i < 16; i++) begin
            rng = xs(rng);
            apply(rng[3:0], rng[4], rng[5], 1'b1);
        end
        end_sim;
    end
endmodule // tb_top
